/* core/gpp_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "gpp_map.vh"
module gpp_port #(
  parameter W = 5
) (
  input wire mclk,
  input wire rst,
  input wire [`GPP_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [W-1:0] pin_in,
  output wire [W-1:0] pin_out,
  output wire [W-1:0] pin_oe_n,
  input wire timer1_wave_out,
  input wire timer3_wave_out,
  input wire timer5_wave_out,
  output wire timer0_clock_in,
  output wire timer4_clock_in
);
  // ===================================================================
  // Registers.
  reg [W-1:0] pin_level_latch_reg;
  reg [W-1:0] direction_select_reg;
  reg [W-1:0] alt_function_select_reg;
  wire [W-1:0] pin_sync;
  wire [W-1:0] timer_wave;
  wire [W-1:0] alt_mask;
  reg [W-1:0] drive_reg;

  gpp_sync #(.W(W)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // Register writes; direction and alt are write-only, so software must
  // keep its own shadow copy instead of reading them back.
  always @(posedge mclk) begin
    if (rst) begin
      pin_level_latch_reg <= `GPP_RST_LATCH;
      direction_select_reg <= `GPP_RST_DIR;
      alt_function_select_reg <= `GPP_RST_ALT;
    end else if (reg_wr) begin
      case (reg_addr)
        `GPP_OFS_DATA: pin_level_latch_reg <= reg_wdata[W-1:0];
        `GPP_OFS_DIR: direction_select_reg <= reg_wdata[W-1:0];
        `GPP_OFS_ALT: alt_function_select_reg <= reg_wdata[W-1:0];
        default: ;
      endcase
    end
  end

  // Reads: only the data register answers with pin levels; write-only
  // and unmapped offsets read as zero.
  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_addr == `GPP_OFS_DATA) begin
      reg_rdata <= {{(8-W){1'b0}}, pin_sync};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ===================================================================
  // Pin multiplexing.
  // Only lines 1, 2 and 4 can take a timer output; 0 and 3 have none.
  assign alt_mask = (5'h1 << `GPP_PIN_T1OUT) | (5'h1 << `GPP_PIN_T3OUT) |
                    (5'h1 << `GPP_PIN_T5OUT);
  assign timer_wave = ({4'h0, timer1_wave_out} << `GPP_PIN_T1OUT) |
                      ({4'h0, timer3_wave_out} << `GPP_PIN_T3OUT) |
                      ({4'h0, timer5_wave_out} << `GPP_PIN_T5OUT);

  // Output data are registered, so a timer wave reaches the pin one
  // cycle late; acceptable for a slow general-purpose port.
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_pin
      always @(posedge mclk) begin
        if (rst) begin
          drive_reg[i] <= 1'b1;
        end else if (alt_function_select_reg[i] && alt_mask[i]) begin
          drive_reg[i] <= timer_wave[i];
        end else begin
          drive_reg[i] <= pin_level_latch_reg[i];
        end
      end
      // Active-low enable: low drives the pin.
      assign pin_oe_n[i] = ~direction_select_reg[i];
    end
  endgenerate
  assign pin_out = drive_reg;

  // Timer clocks follow the pins regardless of direction or mode.
  assign timer0_clock_in = pin_sync[`GPP_PIN_T0CLK];
  assign timer4_clock_in = pin_sync[`GPP_PIN_T4CLK];
endmodule // gpp_port
`default_nettype wire

/* core/gpp_map.vh */
`ifndef GPP_MAP_VH
`define GPP_MAP_VH
// =====================================================================
// Register offsets of the port.
`define GPP_ADDR_W 2
`define GPP_OFS_DATA 2'h0
`define GPP_OFS_DIR 2'h1
`define GPP_OFS_ALT 2'h2
// =====================================================================
// Field positions: pin lines and alternate-function bits.
`define GPP_PIN_T0CLK 0
`define GPP_PIN_T1OUT 1
`define GPP_PIN_T3OUT 2
`define GPP_PIN_T4CLK 3
`define GPP_PIN_T5OUT 4
// =====================================================================
// Reset values.
`define GPP_RST_LATCH 5'h1F
`define GPP_RST_DIR 5'h00
`define GPP_RST_ALT 5'h00
`endif

/* core/gpp_sync.v */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Two-stage synchroniser, one per bit.
module gpp_sync #(
  parameter W = 5
) (
  input wire mclk,
  input wire rst,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  // The first stage feeds only the second; nothing else reads it.
  always @(posedge mclk) begin
    if (rst) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule // gpp_sync
`default_nettype wire

/* sim/gpp_far.sv */
`timescale 1ns/1ps
`default_nettype none
// =====
// Far side: released pins show the outside level, timers free-run.
module gpp_far(input wire logic mclk, input wire logic [4:0] pin_out,
  pin_oe_n, ext_drv, output logic [4:0] pin_in,
  output logic [2:0] tw = 3'h0);
  // A released pin must not echo the latch, so it takes the outside level.
  assign pin_in = pin_out & ~pin_oe_n | ext_drv & pin_oe_n;
  // Counter bits toggle at different rates to expose any wave delay slip.
  always @(posedge mclk) tw <= tw + 3'h1;
endmodule // gpp_far
`default_nettype wire

/* sim/gpp_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// =====
// Port checks; all but the reset check pause while the synchronous reset is high.
module gpp_chk(input wire logic mclk, rst, reg_wr, reg_rd, timer0_clock_in,
  timer4_clock_in, input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  input wire logic [4:0] pin_in, pin_out, pin_oe_n);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rv; disable iff (1'h0) rst |=> pin_oe_n == 5'h1F; endproperty
  a_rv: assert property (p_rv) else $error("reset dir");
  property p_dir;
    reg_wr && reg_addr == 2'h1 |=> pin_oe_n == ~$past(reg_wdata[4:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("dir write");
  property p_lat;
    reg_wr && reg_addr == 2'h0 |=> ##1 pin_out[0] == $past(reg_wdata[0], 2);
  endproperty
  a_lat: assert property (p_lat) else $error("latch");
  property p_clk; !$past(rst) && !$past(rst, 2) |->
    {timer4_clock_in, timer0_clock_in} == $past({pin_in[3], pin_in[0]}, 2);
  endproperty
  a_clk: assert property (p_clk) else $error("timer clk");
  property p_rd; reg_rd && reg_addr == 2'h0 && !$past(rst) && !$past(rst, 2)
    |=> reg_rdata[4:0] == $past(pin_in, 3); endproperty
  a_rd: assert property (p_rd) else $error("pin read");
  property p_wo; reg_rd && reg_addr != 2'h0 |=> reg_rdata == 8'h00;
  endproperty
  a_wo: assert property (p_wo) else $error("write-only read");
endmodule // gpp_chk
bind gpp_port gpp_chk i_gpp_chk (.*);
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// =====
// Bench: reset state, direction, pin reads, timer feed and timer outputs.
module tb_top;
  logic mclk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic timer0_clock_in, timer4_clock_in;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [4:0] pin_in, pin_out, pin_oe_n, ext_drv = 5'h0A;
  logic [2:0] tw, ts;
  int n_fail = 0, cmp_count = 0;
  gpp_port i_gpp_port (.*, .timer1_wave_out(tw[0]),
    .timer3_wave_out(tw[1]), .timer5_wave_out(tw[2]));
  gpp_far i_gpp_far (.*);
  initial forever #5 mclk = ~mclk;
  // A hang is cut off far beyond the few dozen cycles the tests need.
  initial begin
    repeat (400) @(posedge mclk);
    n_fail++;
    print_verdict;
  end
  task chk(logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, s, e);
    end
  endtask
  // One bus cycle; read data is settled when the task returns.
  task acc(logic w, logic [1:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    #1;
  endtask
  task print_verdict;
    $display("%0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    #1;
    chk(pin_oe_n, 8'h1F);
    chk(pin_out, 8'h1F);
    acc(1'h1, 2'h1, 8'hF5);
    chk(pin_oe_n, 8'h0A);
    acc(1'h1, 2'h0, 8'h04);
    repeat (4) @(posedge mclk);
    chk({timer4_clock_in, timer0_clock_in}, 8'h02);
    acc(1'h0, 2'h0, 8'h00);
    chk(reg_rdata, 8'h0E);
    $display("direction test done");
    acc(1'h1, 2'h2, 8'h16);
    acc(1'h1, 2'h1, 8'h1F);
    acc(1'h1, 2'h0, 8'h09);
    ts = tw;
    @(posedge mclk);
    #1;
    chk(pin_out, {ts[2], 1'h1, ts[1], ts[0], 1'h1});
    acc(1'h0, 2'h2, 8'h00);
    chk(reg_rdata, 8'h00);
    $display("timer output test done");
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
